// ---- logic/shift_mask_unit.sv ----
/*
  60-bit shift and mask datapath with an AXI4-Lite register front end.
  Software loads the instruction word, operands and count index, then writes
  the go bit; the result lands in the result operand register two edges later.
  Assumes all inputs synchronous to aclk and a well-behaved AXI4-Lite master.
*/
`timescale 1ns/10ps

module shift_mask_unit (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             busy
);

  localparam int W = shift_unit_pkg::WORD_W;

  typedef struct packed {
    logic                                  awready;
    logic                                  wready;
    logic                                  bvalid;
    logic [1:0]                            bresp;
    logic                                  aw_got;
    logic                                  w_got;
    logic [shift_unit_pkg::ADDR_W-1:0]     aw_addr;
    logic [31:0]                           wdata;
    logic [3:0]                            wstrb;
    logic                                  arready;
    logic                                  rvalid;
    logic [1:0]                            rresp;
    logic [31:0]                           rdata;
    logic [shift_unit_pkg::INSTR_W-1:0]    instr;
    logic [W-1:0]                          result;
    logic [W-1:0]                          source;
    logic [shift_unit_pkg::INDEX_W-1:0]    count_index;
    shift_unit_pkg::seq_e                  seq;
    logic                                  busy;
    logic                                  done;
    logic [W-1:0]                          holding;
    logic                                  comp_flag;
    logic                                  left_circ;
    logic [3:0]                            r1;
    logic [3:0]                            r2;
    logic [3:0]                            r3;
  } state_s;

  state_s st;
  state_s next_st;

  // Byte-lane merge of a write into a 32-bit register image
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return m;
  endfunction

  // Two count bits to one of four flags
  function automatic logic [3:0] decode_pair(input logic [1:0] bits);
    logic [3:0] f;
    f = 4'h0;
    f[bits] = 1'b1;
    return f;
  endfunction

  // One shift rank: amount is flag index times step; no flag gives zeros
  function automatic logic [W-1:0] rank_shift(input logic [W-1:0] x,
                                              input logic [3:0]   flags,
                                              input int           step,
                                              input logic         circ);
    int amt;
    logic [W-1:0] y;
    amt = 0;
    if (flags[1]) begin
      amt = step;
    end else if (flags[2]) begin
      amt = 2 * step;
    end else if (flags[3]) begin
      amt = 3 * step;
    end
    if (circ) begin
      y = (x >> amt) | (x << (W - amt));
    end else begin
      y = x >> amt;
    end
    if (flags == 4'h0) begin
      y = '0;
    end
    return y;
  endfunction

  // Decode of the current instruction word
  logic                      f_bit1;
  logic [1:0]                m_low;
  logic                      is_mask;
  logic                      is_left_imm;
  logic                      is_right_imm;
  logic                      is_left_cnt;
  logic                      is_right_cnt;
  logic [W-1:0]              operand;
  logic                      operand_neg;
  logic                      index_neg;
  logic [5:0]                imm_count;
  logic [5:0]                sel_count;
  logic                      left_circ_now;
  logic                      right_reg_now;
  logic                      over_63;
  logic                      enable_shift;
  logic [W-1:0]              pre_rot;

  // Pure decode of the instruction designators and count paths
  always_comb begin
    f_bit1       = st.instr[shift_unit_pkg::F_LSB + 1];
    m_low        = st.instr[shift_unit_pkg::M_LSB +: 2];
    is_mask      = !f_bit1;
    is_left_imm  = f_bit1 && (m_low == 2'd0);
    is_right_imm = f_bit1 && (m_low == 2'd1);
    is_left_cnt  = f_bit1 && (m_low == 2'd2);
    is_right_cnt = f_bit1 && (m_low == 2'd3);
    // Mode bit 1 low picks the result operand, high the source operand
    operand      = st.instr[shift_unit_pkg::M_LSB + 1] ? st.source : st.result;
    operand_neg  = operand[W-1];
    index_neg    = st.count_index[shift_unit_pkg::INDEX_W-1];
    imm_count    = {st.instr[shift_unit_pkg::J_LSB +: 3], st.instr[shift_unit_pkg::K_LSB +: 3]};
    // Immediate field for 20, 21 and mask; low index bits for the count forms
    sel_count    = (is_left_cnt || is_right_cnt) ? st.count_index[5:0] : imm_count;
    if (is_left_imm || is_left_cnt) begin
      sel_count = ~sel_count;
    end
    // Left circular: 20, 22 with positive index, 23 with negative index
    left_circ_now = is_left_imm || (is_left_cnt && !index_neg)
                    || (is_right_cnt && index_neg);
    right_reg_now = (is_left_cnt && index_neg) || (is_right_cnt && !index_neg);
    // A right shift of more than 63 needs index bits above the low six
    if (is_left_cnt) begin
      over_63 = ~st.count_index[16:6] != 11'h000;
    end else begin
      over_63 = st.count_index[16:6] != 11'h000;
    end
    enable_shift = !(right_reg_now && over_63);
    // Three-place left rotation corrects the complemented count offset
    pre_rot = (operand << shift_unit_pkg::PRE_ROT)
              | (operand >> (W - shift_unit_pkg::PRE_ROT));
  end

  // Datapath through the three ranks while go-shift is up
  logic          go_shift;
  logic [W-1:0]  rank_in;
  logic [W-1:0]  rank1_out;
  logic [W-1:0]  rank2_out;
  logic [W-1:0]  rank3_out;
  logic [W-1:0]  shifter_out;
  logic [W-1:0]  final_word;

  // Complement control, ranks, output drive and sign control
  always_comb begin
    go_shift = (st.seq == shift_unit_pkg::SEQ_SHIFT);
    // Mask holds zeros, so complementing forces all ones into rank 1
    rank_in   = st.comp_flag ? ~st.holding : st.holding;
    rank1_out = rank_shift(rank_in, st.r1, shift_unit_pkg::RANK1_STEP, st.left_circ);
    rank2_out = rank_shift(rank1_out, st.r2, shift_unit_pkg::RANK2_STEP, st.left_circ);
    rank3_out = rank_shift(rank2_out, st.r3, shift_unit_pkg::RANK3_STEP, st.left_circ);
    shifter_out = go_shift ? ~rank3_out : {W{1'b1}};
    // Masks and negative operands, except on an out-of-range right shift, set the flag, so they skip the recomplement
    final_word = st.comp_flag ? shifter_out : ~shifter_out;
  end

  // Whole next state: bus slave, register file and execution sequence
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic [31:0] merged;
  logic [31:0] hi_old;
  logic        go_req;

  always_comb begin
    next_st  = st;
    aw_take  = awvalid && st.awready;
    w_take   = wvalid && st.wready;
    ar_take  = arvalid && st.arready;
    merged   = 32'h00000000;
    hi_old   = 32'h00000000;
    go_req   = 1'b0;
    if (aw_take) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (w_take) begin
      next_st.w_got = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end
    // Write completes once both halves are held and no answer is pending
    do_write = st.aw_got && st.w_got && !st.bvalid;
    if (do_write) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = shift_unit_pkg::RESP_OKAY;
      unique case ({st.aw_addr[7:2], 2'b00})
        shift_unit_pkg::OFS_INSTR: begin
          merged = merge_bytes({17'h00000, st.instr}, st.wdata, st.wstrb);
          next_st.instr = merged[shift_unit_pkg::INSTR_W-1:0];
        end
        shift_unit_pkg::OFS_RESULT_LO: begin
          next_st.result[31:0] = merge_bytes(st.result[31:0], st.wdata, st.wstrb);
        end
        shift_unit_pkg::OFS_RESULT_HI: begin
          hi_old = {4'h0, st.result[W-1:32]};
          merged = merge_bytes(hi_old, st.wdata, st.wstrb);
          next_st.result[W-1:32] = merged[27:0];
        end
        shift_unit_pkg::OFS_SOURCE_LO: begin
          next_st.source[31:0] = merge_bytes(st.source[31:0], st.wdata, st.wstrb);
        end
        shift_unit_pkg::OFS_SOURCE_HI: begin
          hi_old = {4'h0, st.source[W-1:32]};
          merged = merge_bytes(hi_old, st.wdata, st.wstrb);
          next_st.source[W-1:32] = merged[27:0];
        end
        shift_unit_pkg::OFS_COUNT_IDX: begin
          merged = merge_bytes({14'h0000, st.count_index}, st.wdata, st.wstrb);
          next_st.count_index = merged[shift_unit_pkg::INDEX_W-1:0];
        end
        shift_unit_pkg::OFS_CONTROL: begin
          go_req = st.wstrb[0] && st.wdata[shift_unit_pkg::CTL_GO];
        end
        default: begin
          next_st.bresp = shift_unit_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    // Address and data are each taken once per write, in either order
    next_st.awready = !next_st.aw_got && !next_st.bvalid && !do_write;
    next_st.wready  = !next_st.w_got && !next_st.bvalid && !do_write;

    // Read: one outstanding, data registered with the answer
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = shift_unit_pkg::RESP_OKAY;
      unique case ({araddr[7:2], 2'b00})
        shift_unit_pkg::OFS_INSTR:     next_st.rdata = {17'h00000, st.instr};
        shift_unit_pkg::OFS_RESULT_LO: next_st.rdata = st.result[31:0];
        shift_unit_pkg::OFS_RESULT_HI: next_st.rdata = {4'h0, st.result[W-1:32]};
        shift_unit_pkg::OFS_SOURCE_LO: next_st.rdata = st.source[31:0];
        shift_unit_pkg::OFS_SOURCE_HI: next_st.rdata = {4'h0, st.source[W-1:32]};
        shift_unit_pkg::OFS_COUNT_IDX: next_st.rdata = {14'h0000, st.count_index};
        shift_unit_pkg::OFS_CONTROL:   next_st.rdata = {30'h00000000, st.done, st.busy};
        default: begin
          next_st.rdata = 32'h00000000;
          next_st.rresp = shift_unit_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = !next_st.rvalid;

    // Execution: go while idle loads the holding register and flags
    unique case (st.seq)
      shift_unit_pkg::SEQ_IDLE: begin
        if (go_req) begin
          next_st.seq  = shift_unit_pkg::SEQ_SHIFT;
          next_st.busy = 1'b1;
          next_st.done = 1'b0;
          if (is_mask) begin
            next_st.holding = '0;
          end else if (left_circ_now) begin
            next_st.holding = pre_rot;
          end else begin
            next_st.holding = operand;
          end
          // An out-of-range right shift is forced onto the positive path
          next_st.comp_flag = is_mask || (operand_neg && enable_shift);
          next_st.left_circ = left_circ_now;
          next_st.r1 = decode_pair(sel_count[1:0]);
          next_st.r2 = decode_pair(sel_count[3:2]);
          next_st.r3 = enable_shift ? decode_pair(sel_count[5:4]) : 4'h0;
        end
      end
      shift_unit_pkg::SEQ_SHIFT: begin
        // Go-shift cycle: the ranks drive the destination register
        next_st.result = final_word;
        next_st.seq    = shift_unit_pkg::SEQ_IDLE;
        next_st.busy   = 1'b0;
        next_st.done   = 1'b1;
      end
    endcase
  end

  // State register; reset parks the bus ready to accept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st             <= '0;
      st.awready     <= 1'b1;
      st.wready      <= 1'b1;
      st.arready     <= 1'b1;
      st.bresp       <= shift_unit_pkg::RESP_OKAY;
      st.rresp       <= shift_unit_pkg::RESP_OKAY;
      st.instr       <= shift_unit_pkg::INSTR_RESET;
      st.result      <= shift_unit_pkg::WORD_RESET;
      st.source      <= shift_unit_pkg::WORD_RESET;
      st.count_index <= shift_unit_pkg::INDEX_RESET;
      st.seq         <= shift_unit_pkg::SEQ_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign awready = st.awready;
  assign wready  = st.wready;
  assign bvalid  = st.bvalid;
  assign bresp   = st.bresp;
  assign arready = st.arready;
  assign rvalid  = st.rvalid;
  assign rresp   = st.rresp;
  assign rdata   = st.rdata;
  assign busy    = st.busy;

endmodule

// ---- pkg/shift_unit_pkg.sv ----
/*
  Constants, register map and state encoding for the 60-bit shift and mask unit.
  Assumes a single 40 MHz clock and an AXI4-Lite master with 32-bit data.
*/
package shift_unit_pkg;

  // Datapath widths
  localparam int WORD_W  = 60;
  localparam int COUNT_W = 6;
  localparam int INDEX_W = 18;
  localparam int INSTR_W = 15;
  localparam int ADDR_W  = 8;

  // Instruction word layout: f, m, i, j, k designators, three bits each
  localparam int F_LSB = 12;
  localparam int M_LSB = 9;
  localparam int J_LSB = 3;
  localparam int K_LSB = 0;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_INSTR     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RESULT_LO = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RESULT_HI = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SOURCE_LO = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SOURCE_HI = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_COUNT_IDX = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CONTROL   = 8'h18;

  // Control and status bit positions
  localparam int CTL_GO   = 0;
  localparam int STS_BUSY = 0;
  localparam int STS_DONE = 1;

  // Reset values
  localparam logic [INSTR_W-1:0] INSTR_RESET = 15'h0000;
  localparam logic [WORD_W-1:0]  WORD_RESET  = 60'h000000000000000;
  localparam logic [INDEX_W-1:0] INDEX_RESET = 18'h00000;

  // Rank steps in bit positions
  localparam int RANK1_STEP = 1;
  localparam int RANK2_STEP = 4;
  localparam int RANK3_STEP = 16;

  // Left circular pre-correction in bit positions
  localparam int PRE_ROT = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Execution sequence
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b01,
    SEQ_SHIFT = 2'b10
  } seq_e;

endpackage

// ---- test/shift_mask_unit_checker.sv ----
/*
  Port-level checks for the shift and mask unit, bound to its top module.
  Assumes one clock domain and aresetn synchronous, active low.
*/
`timescale 1ns/10ps
module shift_mask_unit_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        busy
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Go-shift lasts one cycle, so a result can only be gated once
  a_busy_one_cycle: assert property (busy |=> !busy)
    else $error("busy held longer than one cycle");
  // Execution only starts on the edge that completes a write
  a_busy_with_go: assert property (busy |-> $rose(bvalid))
    else $error("busy without a completed go write");
  // Write answer two edges after a joint handshake
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  // Stalled responses must not change under the master
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped while stalled");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped while stalled");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer not one cycle after address");
  a_read_release: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not freed after handshake");
  // No new write may be taken while a response is pending
  a_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("write channel open during response");
endmodule

bind shift_mask_unit shift_mask_unit_checker chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .busy(busy));

// ---- test/issue_model.sv ----
/*
  Processor-side model: issues register accesses to the unit over AXI4-Lite.
  Assumes aclk from the bench; slow delays bready and rready by a few cycles.
*/
`timescale 1ns/10ps
module issue_model (
  input  wire logic        aclk,
  input  wire logic        slow,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready,
  output logic             hung
);
  // Idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, hung} = '0;
  end

  // Released payloads are inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (n == 3 && slow) bready <= 1'b1;
    end while (!(bvalid && bready) && n < 64);
    r = bresp;
    bready <= 1'b0;
    if (n >= 64) hung <= 1'b1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (n == 3 && slow) rready <= 1'b1;
    end while (!(rvalid && rready) && n < 64);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 64) hung <= 1'b1;
  endtask
endmodule

// ---- test/shift_mask_unit_tb.sv ----
/*
  Self-checking bench: loads operands and instructions, checks results.
  Assumes the issue_model drives the register bus.
*/
`timescale 1ns/10ps
module shift_mask_unit_tb;
  logic        aclk, aresetn, slow, hung;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, busy;
  logic [31:0] wdata, rdata, g;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          error_cnt, tests_run, tnum, busy_cnt;
  localparam logic [59:0] P = 60'h0123456789ABCDE;
  localparam logic [59:0] N = 60'h9876543210FEDCB;

  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;

  // Go-shift cycles seen on busy, one per executed instruction
  always @(posedge aclk) begin
    if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end

  shift_mask_unit dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .busy(busy));
  issue_model host (.aclk(aclk), .slow(slow), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .hung(hung));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    tests_run++;
    if (v !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h got %h", nm, e, v);
    end
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] d);
    host.wr(a, d, r);
    chk("bresp", {30'h0, shift_unit_pkg::RESP_OKAY}, {30'h0, r});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, g, r);
    chk("rdata", e, g);
    chk("rresp", {30'h0, shift_unit_pkg::RESP_OKAY}, {30'h0, r});
  endtask

  // Reference shifts; counts of 60 and more wrap or saturate
  function automatic logic [59:0] rotl(input logic [59:0] v, input int n);
    n = n % 60;
    return (v << n) | (v >> (60 - n));
  endfunction
  function automatic logic [59:0] sra(input logic [59:0] v, input int n);
    logic signed [59:0] t;
    t = v;
    t = t >>> n; // Counts past the width leave only sign copies
    return t;
  endfunction
  function automatic logic [59:0] model(input logic [2:0] f, input logic [2:0] m,
      input logic [5:0] jk, input logic [59:0] res, input logic [59:0] src,
      input logic [17:0] idx);
    logic [59:0] op;
    logic [17:0] mag;
    op = m[1] ? src : res;
    mag = ~idx;
    if (!f[1]) return (jk >= 60) ? {60{1'b1}} : ~({60{1'b1}} >> jk);
    case (m[1:0])
      2'd0: return rotl(op, jk);
      2'd1: return sra(op, jk);
      2'd2: return !idx[17] ? rotl(op, idx[5:0]) : (|mag[16:6] ? '0 : sra(op, mag[5:0]));
      default: return idx[17] ? rotl(op, mag[5:0]) : (|idx[16:6] ? '0 : sra(op, idx[5:0]));
    endcase
  endfunction

  // One instruction: load, go, read back result and status
  task automatic run(input logic [2:0] f, input logic [2:0] m, input logic [5:0] jk,
      input logic [59:0] res, input logic [59:0] src, input logic [17:0] idx);
    logic [59:0] e;
    int          b0;
    e = model(f, m, jk, res, src, idx);
    b0 = busy_cnt;
    wchk(shift_unit_pkg::OFS_INSTR, {17'h0, f, m, 3'h0, jk});
    wchk(shift_unit_pkg::OFS_RESULT_LO, res[31:0]);
    wchk(shift_unit_pkg::OFS_RESULT_HI, {4'h0, res[59:32]});
    wchk(shift_unit_pkg::OFS_SOURCE_LO, src[31:0]);
    wchk(shift_unit_pkg::OFS_SOURCE_HI, {4'h0, src[59:32]});
    wchk(shift_unit_pkg::OFS_COUNT_IDX, {14'h0, idx});
    wchk(shift_unit_pkg::OFS_CONTROL, 32'h1);
    rchk(shift_unit_pkg::OFS_RESULT_LO, e[31:0]);
    chk("busy", b0 + 1, busy_cnt);
    rchk(shift_unit_pkg::OFS_RESULT_HI, {4'h0, e[59:32]});
    rchk(shift_unit_pkg::OFS_CONTROL, 32'h2);
    tnum++;
    $display("Test %0d finished", tnum);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // A hung bus wait counts as a mismatch
  always @(posedge hung) begin
    error_cnt++;
    wrap_up();
  end

  initial begin
    {aresetn, slow, error_cnt, tests_run, tnum} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(shift_unit_pkg::OFS_INSTR, 32'h0);
    rchk(shift_unit_pkg::OFS_RESULT_HI, 32'h0);
    rchk(shift_unit_pkg::OFS_COUNT_IDX, 32'h0);
    rchk(shift_unit_pkg::OFS_CONTROL, 32'h0);
    host.wr(8'h1C, 32'hFFFFFFFF, r);
    chk("bresp", {30'h0, shift_unit_pkg::RESP_SLVERR}, {30'h0, r});
    host.rd(8'h1C, g, r);
    chk("rresp", {30'h0, shift_unit_pkg::RESP_SLVERR}, {30'h0, r});
    chk("rdata", 32'h0, g);
    $display("Test reset and map finished");
    run(3'h2, 3'h0, 6'h01, P, N, 18'h00009);
    run(3'h2, 3'h0, 6'h3F, N, P, 18'h00000);
    run(3'h2, 3'h1, 6'h04, N, P, 18'h00000);
    run(3'h2, 3'h1, 6'h3F, P, N, 18'h00000);
    run(3'h2, 3'h2, 6'h11, N, P, 18'h00005);
    slow = 1'b1;
    run(3'h2, 3'h2, 6'h00, P, N, 18'h3FFF8);
    run(3'h2, 3'h2, 6'h00, P, N, 18'h3FF9B);
    run(3'h2, 3'h3, 6'h00, P, N, 18'h00040);
    slow = 1'b0;
    run(3'h2, 3'h3, 6'h00, N, N, 18'h3FFF6);
    run(3'h2, 3'h3, 6'h2A, P, N, 18'h00017);
    run(3'h4, 3'h3, 6'h0C, P, N, 18'h00000);
    run(3'h4, 3'h3, 6'h00, N, N, 18'h00000);
    run(3'h4, 3'h3, 6'h3C, P, P, 18'h00000);
    run(3'h6, 3'h4, 6'h05, N, P, 18'h00000);
    run(3'h0, 3'h7, 6'h07, N, P, 18'h00003);
    wrap_up();
  end
endmodule
